// ---- rtl/monitor_port_defs.vh ----
/*
 constants for the monitor serial command port.
 assumes inclusion by the port and its fifo only.
*/
`ifndef MONITOR_PORT_DEFS_VH
`define MONITOR_PORT_DEFS_VH
`define CLK_HZ 100000000
`define BAUD_RATE 9600
`define DIV_HI 1024
`define DIV_LO 512
`define BREAK_ZERO_BITS 10
`define SEC_BYTES 8
`define CMD_END_DELAY_BITS 11
`define ECHO_GAP_BITS 2
`define BREAK_HIGH_BITS 2
`define HOST_GAP_BITS 1
`define OPC_READ 8'h4a
`define VEC_PAGE_USER 8'hff
`define VEC_PAGE_MON 8'hfe
`define SEC_BASE 16'hfff6
`define PLL_IN_HZ 32768
`define PLL_OUT_HZ 2457600
`define FIFO_DEPTH 16
`define FIFO_AW 4
`endif

// ---- rtl/byte_fifo.v ----
/*
 synchronous fifo, parameterised width and depth.
 assumes one clock and active-low asynchronous reset.
*/
`timescale 1ns/10ps
`include "monitor_port_defs.vh"
module byte_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = `FIFO_DEPTH,
  parameter AW = `FIFO_AW
) (
  input wire clk,
  input wire resetn,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output reg [WIDTH-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_reg;
  reg [AW:0] rd_reg;
  wire [AW:0] count = wr_reg - rd_reg;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  always @* begin
    out_data = mem[rd_reg[AW-1:0]];
  end
  always @(posedge clk) begin
    if (push) begin
      mem[wr_reg[AW-1:0]] <= in_data;
    end
  end
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_reg <= {(AW+1){1'b0}};
      rd_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= rd_reg + 1'b1;
      end
    end
  end
endmodule

// ---- rtl/monitor_serial_command_port.v ----
/*
 monitor serial command port: mode latch, baud select, security intake,
 break handling, echo with gaps, and the single-byte read command.
 assumes pins arrive asynchronously; memory answers reads one cycle later.
*/
// Functional notes
// R1 - ten zero bits form a break, not data
// R2 - on break, idle high two bits, echo break
// R3 - wait for eight security bytes first
// R4 - then send ten-zero break as ready signal
// R5 - echo every received byte back
// R6 - eleven-bit pause ends command; break cancels it
// R7 - two-bit gap before echo and read data
// R8 - read data follows echo of last byte
// R9 - host waits one bit after each echo
// R10 - nrz framing, equal transmit and receive rates
// R11 - test voltage entry: select pin picks 1024/512
// R12 - supply-level blank-vector entry uses 1024
// R13 - ground blank-vector entry enables pll multiply
// R14 - supply blank-vector entry: bus is clock/4
// R15 - mode latched at reset pin rising edge
// R16 - monitor vectors fetched from fe page
// R17 - blank-vector entry: watchdog always disabled
// R18 - test-voltage entry: watchdog off while voltage held
// R19 - blank-vector mode exits only on power-on
// R20 - blank-vector entry adds one extra reset
// R21 - read: opcode 4a, address high then low
// R22 - host drives data pin high for serial
// R23 - test entry: bus half or quarter clock
// R24 - security granted only if all eight match
// R25 - one start, eight data lsb first, one stop
`timescale 1ns/10ps
`include "monitor_port_defs.vh"
module monitor_serial_command_port #(
  parameter BIT_CYCLES = `CLK_HZ / `BAUD_RATE
) (
  input wire clk,
  input wire resetn,
  input wire por_n,
  input wire reset_pin,
  input wire hv_on_entry_pin,
  input wire entry_pin_level,
  input wire divider_select_pin,
  input wire reset_vector_blank,
  input wire hv_on_reset_pin,
  input wire monitor_data_pin_in,
  output reg monitor_data_pin_out,
  output reg monitor_data_pin_oe_n,
  output reg monitor_mode,
  output reg [10:0] baud_divide,
  output reg [1:0] bus_clock_div,
  output reg pll_enable,
  output wire watchdog_disable,
  output reg [7:0] vector_page,
  output reg extra_reset_req,
  output reg security_ok,
  output reg [7:0] sec_byte_index,
  output reg mem_rd,
  output reg [15:0] mem_addr,
  input wire [7:0] mem_rdata,
  input wire [7:0] sec_stored_byte
);
  // tx state codes
  localparam TX_IDLE = 3'd0;
  localparam TX_GAP = 3'd1;
  localparam TX_SHIFT = 3'd2;
  localparam TX_PAUSE = 3'd3;
  // command state codes
  localparam C_SEC = 3'd0;
  localparam C_RDY = 3'd1;
  localparam C_OPC = 3'd2;
  localparam C_AHI = 3'd3;
  localparam C_ALO = 3'd4;
  localparam C_DATA = 3'd5;
  // sized copies of the counts, so no assignment truncates silently
  localparam [10:0] DIV_HI_W = `DIV_HI;
  localparam [10:0] DIV_LO_W = `DIV_LO;
  localparam [3:0] LAST_BIT = `BREAK_ZERO_BITS - 1;
  localparam [3:0] LAST_SEC = `SEC_BYTES - 1;
  localparam [3:0] GAP_BITS = `ECHO_GAP_BITS;
  localparam [3:0] PAUSE_BITS = `CMD_END_DELAY_BITS;

  // pin synchronisers
  reg [1:0] rx_sync_reg;
  reg [1:0] rst_sync_reg;
  reg [1:0] hv_sync_reg;
  reg [1:0] hvr_sync_reg;
  reg [1:0] lvl_sync_reg;
  reg [1:0] sel_sync_reg;
  reg [1:0] blank_sync_reg;
  reg [1:0] por_sync_reg;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_sync_reg <= 2'h3;
      rst_sync_reg <= 2'h3;
      hv_sync_reg <= 2'h0;
      hvr_sync_reg <= 2'h0;
      lvl_sync_reg <= 2'h0;
      sel_sync_reg <= 2'h0;
      blank_sync_reg <= 2'h0;
      por_sync_reg <= 2'h0;
    end else begin
      rx_sync_reg <= {rx_sync_reg[0], monitor_data_pin_in};
      rst_sync_reg <= {rst_sync_reg[0], reset_pin};
      hv_sync_reg <= {hv_sync_reg[0], hv_on_entry_pin};
      hvr_sync_reg <= {hvr_sync_reg[0], hv_on_reset_pin};
      lvl_sync_reg <= {lvl_sync_reg[0], entry_pin_level};
      sel_sync_reg <= {sel_sync_reg[0], divider_select_pin};
      blank_sync_reg <= {blank_sync_reg[0], reset_vector_blank};
      por_sync_reg <= {por_sync_reg[0], por_n};
    end
  end
  wire rx = rx_sync_reg[1];
  reg rst_prev_reg;
  reg blank_entry_reg;
  reg hv_entry_reg;
  wire rst_rise = rst_sync_reg[1] && !rst_prev_reg;
  wire por_active = !por_sync_reg[1];

  // mode latch on reset pin rising edge
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      // idle high, so leaving reset is not taken as a pin edge
      rst_prev_reg <= 1'b1;
      monitor_mode <= 1'b0;
      blank_entry_reg <= 1'b0;
      hv_entry_reg <= 1'b0;
      baud_divide <= DIV_HI_W;
      bus_clock_div <= 2'd2;
      pll_enable <= 1'b0;
      vector_page <= `VEC_PAGE_USER;
      extra_reset_req <= 1'b0;
    end else begin
      rst_prev_reg <= rst_sync_reg[1];
      extra_reset_req <= 1'b0;
      if (por_active) begin
        monitor_mode <= 1'b0; // [R19]
        blank_entry_reg <= 1'b0;
        hv_entry_reg <= 1'b0;
        vector_page <= `VEC_PAGE_USER;
        pll_enable <= 1'b0;
      end else if (rst_rise && !blank_entry_reg) begin // [R15] [R19]
        if (hv_sync_reg[1]) begin
          monitor_mode <= 1'b1;
          hv_entry_reg <= 1'b1;
          vector_page <= `VEC_PAGE_MON; // [R16]
          baud_divide <= sel_sync_reg[1] ? DIV_HI_W : DIV_LO_W; // [R11]
          bus_clock_div <= sel_sync_reg[1] ? 2'd2 : 2'd1; // [R23]
        end else if (blank_sync_reg[1]) begin
          monitor_mode <= 1'b1;
          blank_entry_reg <= 1'b1;
          extra_reset_req <= 1'b1; // [R20]
          vector_page <= `VEC_PAGE_MON; // [R16]
          baud_divide <= DIV_HI_W; // [R12]
          bus_clock_div <= 2'd2; // [R14]
          pll_enable <= !lvl_sync_reg[1]; // [R13]
        end else begin
          monitor_mode <= 1'b0;
          vector_page <= `VEC_PAGE_USER;
        end
      end
    end
  end
  // test-voltage entry holds off watchdog only while voltage stays
  assign watchdog_disable = monitor_mode && (blank_entry_reg || // [R17]
    (hv_entry_reg && (hv_sync_reg[1] || hvr_sync_reg[1]))); // [R18]

  // receiver bit timer; transmitter counts the same bit_len [R10]
  reg [15:0] rx_cnt_reg;
  reg [3:0] rx_bit_reg;
  reg rx_busy_reg;
  reg rx_prev_reg;
  reg [8:0] rx_sh_reg;
  reg rx_zero_reg;
  reg rx_done;
  reg rx_break;
  reg [7:0] rx_byte;
  wire [15:0] bit_len = BIT_CYCLES[15:0];
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_cnt_reg <= 16'h0000;
      rx_prev_reg <= 1'b1;
      rx_bit_reg <= 4'h0;
      rx_busy_reg <= 1'b0;
      rx_sh_reg <= 9'h000;
      rx_zero_reg <= 1'b0;
      rx_done <= 1'b0;
      rx_break <= 1'b0;
      rx_byte <= 8'h00;
    end else begin
      rx_done <= 1'b0;
      rx_break <= 1'b0;
      rx_prev_reg <= rx;
      if (!rx_busy_reg) begin
        // falling edge only: a break tail or our own echo starts nothing
        if (!rx && rx_prev_reg && monitor_mode &&
            monitor_data_pin_oe_n) begin
          rx_busy_reg <= 1'b1;
          rx_cnt_reg <= {1'b0, bit_len[15:1]};
          rx_bit_reg <= 4'h0;
          rx_zero_reg <= 1'b1;
        end
      end else if (rx_cnt_reg == 16'h0000) begin
        rx_cnt_reg <= bit_len - 16'h0001;
        rx_zero_reg <= rx_zero_reg && !rx;
        rx_sh_reg <= {rx, rx_sh_reg[8:1]}; // lsb first [R25]
        if (rx_bit_reg == LAST_BIT) begin
          rx_busy_reg <= 1'b0;
          if (rx_zero_reg && !rx) begin
            rx_break <= 1'b1; // [R1]
          end else begin
            rx_done <= 1'b1;
            rx_byte <= rx_sh_reg[8:1];
          end
        end
        rx_bit_reg <= rx_bit_reg + 4'h1;
      end else begin
        rx_cnt_reg <= rx_cnt_reg - 16'h0001;
      end
    end
  end

  // transmit queue
  reg [8:0] q_in_data;
  reg q_in_valid;
  wire q_in_ready;
  wire [8:0] q_out_data;
  wire q_out_valid;
  reg q_out_ready;
  byte_fifo #(.WIDTH(9), .DEPTH(`FIFO_DEPTH), .AW(`FIFO_AW)) txq (
    .clk(clk),
    .resetn(resetn),
    .in_data(q_in_data),
    .in_valid(q_in_valid),
    .in_ready(q_in_ready),
    .out_data(q_out_data),
    .out_valid(q_out_valid),
    .out_ready(q_out_ready)
  );

  // transmitter; bit 8 of a queue word marks a break
  reg [2:0] tx_state_reg;
  reg [15:0] tx_cnt_reg;
  reg [3:0] tx_bit_reg;
  reg [3:0] tx_gap_reg;
  reg [9:0] tx_sh_reg;
  reg tx_brk_reg;
  reg tx_busy;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_state_reg <= TX_IDLE;
      tx_cnt_reg <= 16'h0000;
      tx_bit_reg <= 4'h0;
      tx_gap_reg <= 4'h0;
      tx_sh_reg <= 10'h3ff;
      tx_brk_reg <= 1'b0;
      monitor_data_pin_out <= 1'b1;
      monitor_data_pin_oe_n <= 1'b1;
    end else begin
      case (tx_state_reg)
        TX_IDLE: begin
          monitor_data_pin_oe_n <= 1'b1;
          if (q_out_valid) begin
            tx_brk_reg <= q_out_data[8];
            tx_sh_reg <= q_out_data[8] ? 10'h000 :
              {1'b1, q_out_data[7:0], 1'b0}; // [R25] [R4]
            // two-bit high gap precedes echo, data and break echo
            tx_gap_reg <= GAP_BITS; // [R7] [R2]
            tx_cnt_reg <= bit_len - 16'h0001;
            monitor_data_pin_out <= 1'b1;
            monitor_data_pin_oe_n <= 1'b0;
            tx_state_reg <= TX_GAP;
          end
        end
        TX_GAP: begin
          if (tx_cnt_reg != 16'h0000) begin
            tx_cnt_reg <= tx_cnt_reg - 16'h0001;
          end else if (tx_gap_reg != 4'h1) begin
            tx_gap_reg <= tx_gap_reg - 4'h1;
            tx_cnt_reg <= bit_len - 16'h0001;
          end else begin
            tx_bit_reg <= 4'h0;
            tx_cnt_reg <= bit_len - 16'h0001;
            monitor_data_pin_out <= tx_sh_reg[0];
            tx_state_reg <= TX_SHIFT;
          end
        end
        TX_SHIFT: begin
          if (tx_cnt_reg != 16'h0000) begin
            tx_cnt_reg <= tx_cnt_reg - 16'h0001;
          end else if (tx_bit_reg != LAST_BIT) begin
            tx_bit_reg <= tx_bit_reg + 4'h1;
            tx_sh_reg <= {1'b1, tx_sh_reg[9:1]};
            monitor_data_pin_out <= tx_brk_reg ? 1'b0 : tx_sh_reg[1];
            tx_cnt_reg <= bit_len - 16'h0001;
          end else begin
            // release high for one bit so the host sees a clean end
            monitor_data_pin_out <= 1'b1;
            tx_cnt_reg <= bit_len - 16'h0001;
            tx_state_reg <= TX_PAUSE;
          end
        end
        TX_PAUSE: begin
          if (tx_cnt_reg != 16'h0000) begin
            tx_cnt_reg <= tx_cnt_reg - 16'h0001;
          end else begin
            monitor_data_pin_oe_n <= 1'b1;
            tx_state_reg <= TX_IDLE;
          end
        end
        default: tx_state_reg <= TX_IDLE;
      endcase
    end
  end
  always @* begin
    q_out_ready = (tx_state_reg == TX_IDLE);
    tx_busy = (tx_state_reg != TX_IDLE) || q_out_valid;
  end

  // command interpreter
  reg [2:0] cmd_state_reg;
  reg [3:0] sec_cnt_reg;
  reg sec_match_reg;
  reg [7:0] opc_reg;
  reg [15:0] pause_reg;
  reg [3:0] pause_bits_reg;
  reg pausing_reg;
  reg rd_pend_reg;
  always @* begin
    q_in_valid = 1'b0;
    q_in_data = 9'h000;
    if (rx_break) begin
      q_in_valid = 1'b1;
      q_in_data = 9'h100; // [R2]
    end else if (rd_pend_reg) begin
      q_in_valid = 1'b1;
      q_in_data = {1'b0, mem_rdata}; // [R8]
    end else if (cmd_state_reg == C_RDY && !tx_busy) begin
      q_in_valid = 1'b1;
      q_in_data = 9'h100; // [R4]
    end else if (rx_done) begin
      q_in_valid = 1'b1;
      q_in_data = {1'b0, rx_byte}; // [R5]
    end
  end
  // a full queue drops the word; host pacing keeps it shallow [R9]
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cmd_state_reg <= C_SEC;
      sec_cnt_reg <= 4'h0;
      sec_match_reg <= 1'b1;
      security_ok <= 1'b0;
      sec_byte_index <= 8'h00;
      opc_reg <= 8'h00;
      mem_rd <= 1'b0;
      mem_addr <= 16'h0000;
      rd_pend_reg <= 1'b0;
      pause_reg <= 16'h0000;
      pause_bits_reg <= 4'h0;
      pausing_reg <= 1'b0;
    end else begin
      mem_rd <= 1'b0;
      rd_pend_reg <= mem_rd;
      if (!monitor_mode) begin
        cmd_state_reg <= C_SEC;
        sec_cnt_reg <= 4'h0;
        sec_match_reg <= 1'b1;
        sec_byte_index <= 8'h00;
        // a pause cut short by a mode exit must not block the next read
        pausing_reg <= 1'b0;
      end else if (rx_break) begin
        cmd_state_reg <= (cmd_state_reg == C_SEC) ? C_SEC : C_OPC; // [R6]
        pausing_reg <= 1'b0;
      end else begin
        case (cmd_state_reg)
          C_SEC: if (rx_done) begin // [R3]
            sec_match_reg <= sec_match_reg &&
              (rx_byte == sec_stored_byte); // [R24]
            sec_byte_index <= sec_byte_index + 8'h01;
            sec_cnt_reg <= sec_cnt_reg + 4'h1;
            if (sec_cnt_reg == LAST_SEC) begin
              security_ok <= sec_match_reg &&
                (rx_byte == sec_stored_byte); // [R24]
              cmd_state_reg <= C_RDY;
            end
          end
          C_RDY: if (!tx_busy && q_in_ready) begin
            cmd_state_reg <= C_OPC;
          end
          C_OPC: if (rx_done) begin
            opc_reg <= rx_byte;
            if (rx_byte == `OPC_READ) begin // [R21]
              cmd_state_reg <= C_AHI;
            end
          end
          C_AHI: if (rx_done) begin
            mem_addr[15:8] <= rx_byte;
            cmd_state_reg <= C_ALO;
          end
          C_ALO: if (rx_done) begin
            mem_addr[7:0] <= rx_byte;
            cmd_state_reg <= C_DATA;
          end
          C_DATA: if (!q_out_valid && !rd_pend_reg && !mem_rd &&
              !pausing_reg && q_in_ready) begin
            // echo of address low is queued ahead of the data [R8]
            mem_rd <= 1'b1;
            pausing_reg <= 1'b1;
            pause_bits_reg <= PAUSE_BITS;
            pause_reg <= bit_len - 16'h0001;
          end else if (pausing_reg && !tx_busy) begin
            if (pause_reg != 16'h0000) begin
              pause_reg <= pause_reg - 16'h0001;
            end else if (pause_bits_reg != 4'h1) begin
              pause_bits_reg <= pause_bits_reg - 4'h1;
              pause_reg <= bit_len - 16'h0001;
            end else begin
              pausing_reg <= 1'b0; // [R6]
              cmd_state_reg <= C_OPC;
            end
          end
          default: cmd_state_reg <= C_SEC;
        endcase
      end
    end
  end
endmodule

// ---- bench/monitor_port_chk.sv ----
/*
 assertion checker for the monitor serial command port.
 assumes BIT_CYCLES equals the value of the bound port instance.
*/
`timescale 1ns/10ps
module monitor_port_chk #(
  parameter BIT_CYCLES = 16
) (
  input wire clk,
  input wire resetn,
  input wire hv_on_entry_pin,
  input wire monitor_data_pin_out,
  input wire monitor_data_pin_oe_n,
  input wire monitor_mode,
  input wire [10:0] baud_divide,
  input wire [1:0] bus_clock_div,
  input wire watchdog_disable,
  input wire [7:0] vector_page,
  input wire extra_reset_req
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // cycles since the port took the wire
  reg [15:0] drv_cnt;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) drv_cnt <= 16'h0000;
    else if (monitor_data_pin_oe_n) drv_cnt <= 16'h0000;
    else drv_cnt <= drv_cnt + 16'h0001;
  end
  sequence s_take_wire;
    $fell(monitor_data_pin_oe_n);
  endsequence
  sequence s_idle_high;
    (monitor_data_pin_out && !monitor_data_pin_oe_n) [*8];
  endsequence
  property p_gap_start;
    s_take_wire |-> s_idle_high;
  endproperty
  a_gap_start: assert property (p_gap_start)
    else $error("transmit without leading high gap");
  property p_gap_whole;
    (!monitor_data_pin_oe_n && drv_cnt < 2*BIT_CYCLES)
      |-> monitor_data_pin_out;
  endproperty
  a_gap_whole: assert property (p_gap_whole)
    else $error("gap shorter than two bits");
  property p_start_bit;
    (!monitor_data_pin_oe_n && drv_cnt == 2*BIT_CYCLES + BIT_CYCLES/2)
      |-> !monitor_data_pin_out;
  endproperty
  a_start_bit: assert property (p_start_bit)
    else $error("start bit not low");
  property p_trail_high;
    (!monitor_data_pin_oe_n && drv_cnt == 12*BIT_CYCLES + BIT_CYCLES/2)
      |-> monitor_data_pin_out;
  endproperty
  a_trail_high: assert property (p_trail_high)
    else $error("frame not followed by high");
  // a merged echo and data frame would fail here, on purpose
  property p_drive_len;
    $rose(monitor_data_pin_oe_n) |-> ($past(drv_cnt) >= 12*BIT_CYCLES
      && $past(drv_cnt) <= 13*BIT_CYCLES);
  endproperty
  a_drive_len: assert property (p_drive_len)
    else $error("frame length wrong");
  property p_page_mon;
    $rose(monitor_mode) |-> ##[0:2] vector_page == 8'hfe;
  endproperty
  a_page_mon: assert property (p_page_mon)
    else $error("vector page not fe in monitor");
  property p_page_user;
    $fell(monitor_mode) |-> ##[0:2] vector_page == 8'hff;
  endproperty
  a_page_user: assert property (p_page_user)
    else $error("vector page not ff after exit");
  property p_div_pair;
    (monitor_mode && $stable(baud_divide) && $stable(bus_clock_div))
      |-> ((bus_clock_div == 2'h1) == (baud_divide == 11'h200));
  endproperty
  a_div_pair: assert property (p_div_pair)
    else $error("bus divider and baud divider disagree");
  property p_xrst_pulse;
    extra_reset_req |=> !extra_reset_req;
  endproperty
  a_xrst_pulse: assert property (p_xrst_pulse)
    else $error("extra reset longer than one cycle");
  property p_wdog_hv;
    (monitor_mode && hv_on_entry_pin) [*4] |-> watchdog_disable;
  endproperty
  a_wdog_hv: assert property (p_wdog_hv)
    else $error("watchdog on under test voltage");
endmodule
bind monitor_serial_command_port monitor_port_chk #(
  .BIT_CYCLES(BIT_CYCLES)
) u_chk (.clk(clk), .resetn(resetn), .hv_on_entry_pin(hv_on_entry_pin),
  .monitor_data_pin_out(monitor_data_pin_out),
  .monitor_data_pin_oe_n(monitor_data_pin_oe_n),
  .monitor_mode(monitor_mode), .baud_divide(baud_divide),
  .bus_clock_div(bus_clock_div), .watchdog_disable(watchdog_disable),
  .vector_page(vector_page), .extra_reset_req(extra_reset_req));

// ---- bench/host_model.sv ----
/*
 host programmer model on the serial pin.
 assumes the bench resolves the wire; host drives whenever port is off.
*/
`timescale 1ns/10ps
module host_model #(
  parameter BIT = 16
) (
  input wire clk,
  input wire line,
  output reg tx
);
  initial tx = 1'b1; // serial select, idle mark
  // frame bits lsb first
  task send_bits(input [9:0] b);
    integer i;
    begin
      for (i = 0; i < 10; i = i + 1) begin
        tx = b[i];
        repeat (BIT) @(negedge clk);
      end
      tx = 1'b1;
    end
  endtask
  // all-zero frame is a break
  task recv(output [9:0] b, output ok);
    integer i;
    begin
      ok = 1'b0;
      b = 10'h3ff;
      for (i = 0; i < 60*BIT && !ok; i = i + 1) begin
        @(negedge clk);
        ok = !line;
      end
      if (ok) begin
        repeat (BIT/2) @(negedge clk);
        for (i = 0; i < 10; i = i + 1) begin
          b[i] = line;
          repeat (BIT) @(negedge clk);
        end
        repeat (BIT) @(negedge clk); // extra bit before next byte
      end
    end
  endtask
endmodule

// ---- bench/monitor_serial_command_port_tb.sv ----
/*
 bench for the monitor serial port with host model and memory stub.
 assumes the port is built with a short bit time.
*/
`timescale 1ns/10ps
module monitor_serial_command_port_tb;
  localparam BIT = 16;
  reg clk;
  reg resetn;
  reg por_n;
  reg reset_pin;
  reg hv_on_entry_pin;
  reg entry_pin_level;
  reg divider_select_pin;
  reg reset_vector_blank;
  reg hv_on_reset_pin;
  reg [7:0] mem_rdata;
  reg [15:0] got_addr;
  integer fails;
  integer checks_done;
  integer xr;
  wire tx;
  wire line;
  wire pin_out;
  wire pin_oe_n;
  wire monitor_mode;
  wire [10:0] baud_divide;
  wire [1:0] bus_clock_div;
  wire pll_enable;
  wire watchdog_disable;
  wire [7:0] vector_page;
  wire extra_reset_req;
  wire security_ok;
  wire [7:0] sec_byte_index;
  wire mem_rd;
  wire [15:0] mem_addr;
  wire [7:0] sec_stored_byte;
  assign sec_stored_byte = 8'ha0 + sec_byte_index;
  assign line = pin_oe_n ? tx : pin_out;
  always #5 clk = ~clk;
  // data answers one cycle after the request
  always @(negedge clk) begin
    if (mem_rd) begin
      mem_rdata <= mem_addr[15:8] ^ mem_addr[7:0];
      got_addr <= mem_addr;
    end
  end
  monitor_serial_command_port #(.BIT_CYCLES(BIT)) DUT (.clk(clk),
    .resetn(resetn), .por_n(por_n), .reset_pin(reset_pin),
    .hv_on_entry_pin(hv_on_entry_pin), .entry_pin_level(entry_pin_level),
    .divider_select_pin(divider_select_pin),
    .reset_vector_blank(reset_vector_blank),
    .hv_on_reset_pin(hv_on_reset_pin), .monitor_data_pin_in(line),
    .monitor_data_pin_out(pin_out), .monitor_data_pin_oe_n(pin_oe_n),
    .monitor_mode(monitor_mode), .baud_divide(baud_divide),
    .bus_clock_div(bus_clock_div), .pll_enable(pll_enable),
    .watchdog_disable(watchdog_disable), .vector_page(vector_page),
    .extra_reset_req(extra_reset_req), .security_ok(security_ok),
    .sec_byte_index(sec_byte_index), .mem_rd(mem_rd), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata), .sec_stored_byte(sec_stored_byte));
  host_model #(.BIT(BIT)) host (.clk(clk), .line(line), .tx(tx));
  task chk(input [15:0] s, input [15:0] e);
    begin
      checks_done = checks_done + 1;
      if (s !== e) begin
        fails = fails + 1;
        $display("Error at %0t: got %h want %h", $time, s, e);
      end
    end
  endtask
  task close_out;
    begin
      if (fails == 0 && checks_done > 0) begin
        $display("TB: PASS");
      end else begin
        $display("TB: FAIL");
      end
      $finish;
    end
  endtask
  task rx(input [9:0] e);
    reg [9:0] b;
    reg ok;
    begin
      host.recv(b, ok);
      if (!ok) begin
        fails = fails + 1;
        close_out;
      end else begin
        chk({6'h00, b}, {6'h00, e});
      end
    end
  endtask
  task xb(input [7:0] d);
    begin
      host.send_bits({1'b1, d, 1'b0});
      rx({1'b1, d, 1'b0});
    end
  endtask
  // pulse the reset pin, counting extra reset pulses
  task enter(input hv, input lvl, input sel, input blank);
    integer i;
    begin
      hv_on_entry_pin = hv;
      entry_pin_level = lvl;
      divider_select_pin = sel;
      reset_vector_blank = blank;
      reset_pin = 1'b0;
      xr = 0;
      for (i = 0; i < 16; i = i + 1) begin
        @(negedge clk);
        if (i == 4) reset_pin = 1'b1;
        if (extra_reset_req === 1'b1) xr = xr + 1;
      end
    end
  endtask
  task t_blank_supply;
    begin
      enter(1'b0, 1'b1, 1'b0, 1'b1);
      chk(monitor_mode, 1'b1);
      chk(xr, 1);
      chk(baud_divide, 11'h400);
      chk(bus_clock_div, 2'h2);
      chk(pll_enable, 1'b0);
      chk(vector_page, 8'hfe);
      reset_vector_blank = 1'b0;
      entry_pin_level = 1'b0;
      repeat (6) @(negedge clk);
      chk(monitor_mode, 1'b1);
      chk(watchdog_disable, 1'b1);
    end
  endtask
  task t_security_read;
    reg [7:0] k;
    begin
      for (k = 8'h00; k < 8'h08; k = k + 8'h01) xb(8'ha0 + k);
      rx(10'h000);
      chk(security_ok, 1'b1);
      xb(8'h4a);
      xb(8'h12);
      xb(8'h34);
      rx({1'b1, 8'h26, 1'b0});
      chk(got_addr, 16'h1234);
      // break inside the closing pause cancels and is answered
      host.send_bits(10'h000);
      rx(10'h000);
      xb(8'h4a);
      xb(8'h00);
      xb(8'h07);
      rx({1'b1, 8'h07, 1'b0});
    end
  endtask
  task t_pin_reset_por;
    begin
      enter(1'b0, 1'b0, 1'b0, 1'b0);
      chk(monitor_mode, 1'b1);
      chk(watchdog_disable, 1'b1);
      por_n = 1'b0;
      repeat (5) @(negedge clk);
      por_n = 1'b1;
      repeat (5) @(negedge clk);
      chk(monitor_mode, 1'b0);
      chk(vector_page, 8'hff);
    end
  endtask
  task t_test_voltage;
    begin
      enter(1'b1, 1'b1, 1'b0, 1'b0);
      chk(baud_divide, 11'h200);
      chk(bus_clock_div, 2'h1);
      chk(watchdog_disable, 1'b1);
      hv_on_entry_pin = 1'b0;
      repeat (6) @(negedge clk);
      chk(watchdog_disable, 1'b0);
      hv_on_reset_pin = 1'b1;
      repeat (6) @(negedge clk);
      chk(watchdog_disable, 1'b1);
      hv_on_reset_pin = 1'b0;
      enter(1'b1, 1'b1, 1'b1, 1'b0);
      chk(baud_divide, 11'h400);
      chk(bus_clock_div, 2'h2);
    end
  endtask
  task t_ground;
    begin
      enter(1'b0, 1'b0, 1'b0, 1'b1);
      chk(monitor_mode, 1'b1);
      chk(pll_enable, 1'b1);
      chk(xr, 1);
    end
  endtask
  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    por_n = 1'b1;
    reset_pin = 1'b1;
    hv_on_entry_pin = 1'b0;
    entry_pin_level = 1'b1;
    divider_select_pin = 1'b0;
    reset_vector_blank = 1'b0;
    hv_on_reset_pin = 1'b0;
    mem_rdata = 8'h00;
    got_addr = 16'h0000;
    fails = 0;
    checks_done = 0;
    xr = 0;
    repeat (20) @(negedge clk);
    resetn = 1'b1;
    @(negedge clk);
    chk(vector_page, 8'hff);
    chk(monitor_mode, 1'b0);
    t_blank_supply;
    t_security_read;
    t_pin_reset_por;
    t_test_voltage;
    t_ground;
    close_out;
  end
endmodule
